// ---- logic/vtp_params.svh ----
/*
 * constants of the video test pattern generator: register indices,
 * field positions, reset values, indirect map and divider settings.
 * assumes it is included by bare name from the design file.
 */
`ifndef VTP_PARAMS_SVH
`define VTP_PARAMS_SVH

// register indices, byte address is four times the index
`define VTP_IDX_GEN_CTRL   8'h64
`define VTP_IDX_CONFIG     8'h65
`define VTP_IDX_IND_ADDR   8'h66
`define VTP_IDX_IND_DATA   8'h67
`define VTP_IDX_DEBUG      8'h68
`define VTP_IDX_TEST_STAT  8'h69
`define VTP_IDX_FRAME_TIME 8'h6a
`define VTP_IDX_IRQ_STAT   8'h6b
`define VTP_IDX_IRQ_MASK   8'h6c

// field positions
`define VTP_CTL_EN      0
`define VTP_CFG_DEPTH18 4
`define VTP_CFG_EXTCLK  3
`define VTP_CFG_TSEL    2
`define VTP_CFG_INV     1
`define VTP_CFG_ASCRL   0
`define VTP_DBG_BIST    3
`define VTP_STAT_ERR    7
`define VTP_IRQ_FRAME   0
`define VTP_IRQ_SCROLL  1
`define VTP_IRQ_MISM    2

// writable masks and reset values
`define VTP_CFG_MASK    8'h1f
`define VTP_DBG_MASK    8'h08
`define VTP_CTL_MASK    8'h01
`define VTP_IRQ_MASK_W  8'h07
`define VTP_RST8        8'h00
`define VTP_RST16       16'h0000
`define VTP_RST32       32'h00000000

// indirect map
`define VTP_IND_PAT_MASK 8'h00
`define VTP_IND_HTOT_LO  8'h01
`define VTP_IND_HTOT_HI  8'h02
`define VTP_IND_VTOT_LO  8'h03
`define VTP_IND_VTOT_HI  8'h04
`define VTP_IND_HACT_LO  8'h05
`define VTP_IND_HACT_HI  8'h06
`define VTP_IND_VACT_LO  8'h07
`define VTP_IND_VACT_HI  8'h08
`define VTP_IND_HSW      8'h09
`define VTP_IND_VSW      8'h0a
`define VTP_IND_HBP      8'h0b
`define VTP_IND_VBP      8'h0c
`define VTP_IND_SYNC_CFG 8'h0d
`define VTP_IND_BIST_CNT 8'h0e

// internal divided pixel clock: one pixel every VTP_DIV_RATIO hclk cycles
`define VTP_DIV_RATIO   4'd2
`define VTP_DIV_ONE     4'd1
`define VTP_ONE16       16'h0001
`define VTP_ONE8        8'h01
`define VTP_CNT_MAX     8'hff
`define VTP_MASK18      24'hfcfcfc
`define VTP_MASK24      24'hffffff

`endif

// ---- logic/vtp_pkg.sv ----
/*
 * types shared by the video test pattern generator.
 * assumes vtp_params.svh is on the include path.
 */
package vtp_pkg;
   typedef logic [23:0] vtp_rgb_t;
   typedef logic [2:0]  vtp_pat_t;
   // pixel tick source, one-hot
   typedef enum logic [1:0] {
      VTP_SRC_EXT = 2'b01,
      VTP_SRC_DIV = 2'b10
   } vtp_src_e;
endpackage

// ---- logic/vtp_generator.sv ----
/*
 * video test pattern generator with its ahb-lite register slave.
 * assumes one clock hclk, video pins asynchronous to it, one ahb master
 * whose hready is this slave's hreadyout.
 */
// Implementation choice: the AHB-Lite interface to the registers.
`include "vtp_params.svh"

module vtp_generator (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        ext_pclk,
   input  wire logic        ext_de,
   input  wire logic        ext_hs,
   input  wire logic        ext_vs,
   input  wire logic [23:0] rx_rgb,
   output logic             vid_de,
   output logic             vid_hs,
   output logic             vid_vs,
   output logic [23:0]      vid_rgb,
   output logic             irq
);

   // registers
   logic [7:0]  generator_control;
   logic [7:0]  pattern_config;
   logic [7:0]  pattern_indirect_address;
   logic [7:0]  pattern_debug_control;
   logic [7:0]  frame_time_setting;
   logic [7:0]  irq_status;
   logic [7:0]  irq_mask;
   logic [7:0]  ind_mem [0:255];
   logic [7:0]  bist_count;

   // bus state
   logic        wr_pend;
   logic        rd_pend;
   logic [7:0]  acc_idx;

   // pin synchroniser
   logic [27:0] pin_s1;
   logic [27:0] pin_s2;
   logic [27:0] pin_s3;
   logic [27:0] pin_q;
   logic        pclk_prev;
   logic        vs_prev;
   logic        de_prev;

   // video state
   logic [3:0]            div_cnt;
   logic [15:0]           hcnt;
   logic [15:0]           vcnt;
   logic [7:0]            frame_cnt;
   vtp_pkg::vtp_pat_t     cur_pat;
   logic                  bist_prev;

   // helpers
   logic                  addr_ok;
   logic [7:0]            rd_value;
   vtp_pkg::vtp_src_e     src;
   logic                  tick;
   logic                  ext_rise;
   logic                  frame_end;
   logic                  h_wrap;
   logic                  v_wrap;
   logic                  en;
   logic                  tsel;
   logic                  depth18;
   logic                  gen_de;
   logic                  gen_hs;
   logic                  gen_vs;
   logic [15:0]           hstart;
   logic [15:0]           vstart;
   logic                  mismatch;
   logic                  scroll_now;
   vtp_pkg::vtp_rgb_t     local_rgb;

   // two indirect bytes to one 16-bit figure
   function automatic logic [15:0] ind16(input logic [7:0] lo, input logic [7:0] hi);
      ind16 = {hi, lo};
   endfunction

   // next enabled pattern after cur, wrapping; stays put when none enabled
   function automatic vtp_pkg::vtp_pat_t next_pattern(input vtp_pkg::vtp_pat_t cur,
                                                       input logic [7:0] mask);
      vtp_pkg::vtp_pat_t cand;
      next_pattern = cur;
      cand = cur;
      for (int i = 1; i < 8; i++) begin
         cand = vtp_pkg::vtp_pat_t'(cur + i[2:0]);
         if (mask[cand] && next_pattern == cur) begin
            next_pattern = cand;
         end
      end
   endfunction

   // colour at a position; depth and inversion applied here
   function automatic vtp_pkg::vtp_rgb_t pattern_colour(input vtp_pkg::vtp_pat_t pat,
                                                        input logic [15:0] h,
                                                        input logic [15:0] v,
                                                        input logic d18,
                                                        input logic inv);
      logic [7:0]        lvl;
      logic [23:0]       mask;
      vtp_pkg::vtp_rgb_t c;
      lvl  = d18 ? {h[5:0], 2'b00} : h[7:0]; // 64 or 256 levels
      mask = d18 ? `VTP_MASK18 : `VTP_MASK24; // low bits stay zero
      unique case (pat)
         3'd0: c = `VTP_MASK24;
         3'd1: c = {lvl, 8'h00, 8'h00};
         3'd2: c = {8'h00, lvl, 8'h00};
         3'd3: c = {8'h00, 8'h00, lvl};
         3'd4: c = {lvl, lvl, lvl};
         3'd5: begin
            // white, yellow, cyan, green, magenta, red, blue, black
            unique case (h[9:7])
               3'd0: c = 24'hffffff;
               3'd1: c = 24'hffff00;
               3'd2: c = 24'h00ffff;
               3'd3: c = 24'h00ff00;
               3'd4: c = 24'hff00ff;
               3'd5: c = 24'hff0000;
               3'd6: c = 24'h0000ff;
               3'd7: c = 24'h000000;
            endcase
         end
         3'd6: c = (h[4] ^ v[4]) ? `VTP_MASK24 : 24'h000000;
         3'd7: c = 24'h000000;
      endcase
      c = c & mask;
      if (inv) begin
         c = ~c & mask;
      end
      pattern_colour = c;
   endfunction

   assign en      = generator_control[`VTP_CTL_EN];
   assign tsel    = pattern_config[`VTP_CFG_TSEL];
   assign depth18 = pattern_config[`VTP_CFG_DEPTH18];

   // address window check: word aligned, within the first 256 word indices
   assign addr_ok = (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h000000);

   // ahb-lite address phase capture; reads take one wait state so a write
   // in the preceding data phase is already visible when the read samples
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend   <= 1'b0;
         rd_pend   <= 1'b0;
         acc_idx   <= `VTP_RST8;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (ce) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         if (rd_pend) begin
            hreadyout <= 1'b1;
         end else if (hsel && hready && htrans[1]) begin
            acc_idx   <= addr_ok ? haddr[9:2] : `VTP_CNT_MAX;
            wr_pend   <= hwrite;
            rd_pend   <= ~hwrite;
            hreadyout <= hwrite;
         end
      end
   end

   // read mux; unmapped indices read zero
   always_comb begin
      rd_value = `VTP_RST8;
      unique case (acc_idx)
         `VTP_IDX_GEN_CTRL:   rd_value = generator_control;
         `VTP_IDX_CONFIG:     rd_value = pattern_config;
         `VTP_IDX_IND_ADDR:   rd_value = pattern_indirect_address;
         `VTP_IDX_IND_DATA: begin
            if (pattern_indirect_address == `VTP_IND_BIST_CNT) begin
               rd_value = bist_count;
            end else begin
               rd_value = ind_mem[pattern_indirect_address];
            end
         end
         `VTP_IDX_DEBUG:      rd_value = pattern_debug_control;
         `VTP_IDX_TEST_STAT:  rd_value = {(bist_count != `VTP_RST8), 7'b0000000};
         `VTP_IDX_FRAME_TIME: rd_value = frame_time_setting;
         `VTP_IDX_IRQ_STAT:   rd_value = irq_status;
         `VTP_IDX_IRQ_MASK:   rd_value = irq_mask;
         default:             rd_value = `VTP_RST8;
      endcase
   end

   // read data register, loaded in the wait cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= `VTP_RST32;
      end else if (ce && rd_pend) begin
         hrdata <= {24'h000000, rd_value};
      end
   end

   // direct registers written in the data phase, byte in low lane
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         generator_control        <= `VTP_RST8;
         pattern_config           <= `VTP_RST8;
         pattern_indirect_address <= `VTP_RST8;
         pattern_debug_control    <= `VTP_RST8;
         frame_time_setting       <= `VTP_RST8;
         irq_mask                 <= `VTP_RST8;
      end else if (ce && wr_pend) begin
         unique case (acc_idx)
            `VTP_IDX_GEN_CTRL:   generator_control <= hwdata[7:0] & `VTP_CTL_MASK;
            `VTP_IDX_CONFIG:     pattern_config <= hwdata[7:0] & `VTP_CFG_MASK;
            `VTP_IDX_IND_ADDR:   pattern_indirect_address <= hwdata[7:0];
            `VTP_IDX_DEBUG:      pattern_debug_control <= hwdata[7:0] & `VTP_DBG_MASK;
            `VTP_IDX_FRAME_TIME: frame_time_setting <= hwdata[7:0];
            `VTP_IDX_IRQ_MASK:   irq_mask <= hwdata[7:0] & `VTP_IRQ_MASK_W;
            default: ;
         endcase
      end
   end

   // indirect store; the count slot is read-only and lives in bist_count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 256; i++) begin
            ind_mem[i] <= `VTP_RST8;
         end
      end else if (ce && wr_pend && acc_idx == `VTP_IDX_IND_DATA &&
                   pattern_indirect_address != `VTP_IND_BIST_CNT) begin
         ind_mem[pattern_indirect_address] <= hwdata[7:0];
      end
   end

   // three-stage pin synchroniser; a bit moves once stages two and three agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1 <= 28'h0000000;
         pin_s2 <= 28'h0000000;
         pin_s3 <= 28'h0000000;
         pin_q  <= 28'h0000000;
      end else if (ce) begin
         pin_s1 <= {ext_pclk, ext_de, ext_hs, ext_vs, rx_rgb};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_q  <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_q & (pin_s2 ^ pin_s3));
      end
   end

   // edge history of the cleaned pins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pclk_prev <= 1'b0;
         vs_prev   <= 1'b0;
      end else if (ce) begin
         pclk_prev <= pin_q[27];
         vs_prev   <= pin_q[24];
      end
   end

   // pixel clock sampled on hclk: needs hclk well above twice its rate
   assign ext_rise = pin_q[27] & ~pclk_prev;
   assign src      = (tsel && !pattern_config[`VTP_CFG_EXTCLK]) ? vtp_pkg::VTP_SRC_DIV
                                                              : vtp_pkg::VTP_SRC_EXT;

   // internal divided clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt <= 4'h0;
      end else if (ce) begin
         div_cnt <= (div_cnt >= `VTP_DIV_RATIO - `VTP_DIV_ONE) ? 4'h0 : div_cnt + `VTP_DIV_ONE;
      end
   end

   always_comb begin
      tick = 1'b0;
      unique case (src)
         vtp_pkg::VTP_SRC_EXT: tick = ext_rise;
         vtp_pkg::VTP_SRC_DIV: tick = (div_cnt == 4'h0);
      endcase
   end

   // internal timing windows from the indirect map
   assign hstart = 16'(ind_mem[`VTP_IND_HSW]) + 16'(ind_mem[`VTP_IND_HBP]);
   assign vstart = 16'(ind_mem[`VTP_IND_VSW]) + 16'(ind_mem[`VTP_IND_VBP]);
   assign h_wrap = hcnt >= ind16(ind_mem[`VTP_IND_HTOT_LO], ind_mem[`VTP_IND_HTOT_HI]) - `VTP_ONE16;
   assign v_wrap = vcnt >= ind16(ind_mem[`VTP_IND_VTOT_LO], ind_mem[`VTP_IND_VTOT_HI]) - `VTP_ONE16;
   assign gen_hs = (hcnt < 16'(ind_mem[`VTP_IND_HSW])) ^ ind_mem[`VTP_IND_SYNC_CFG][0];
   assign gen_vs = (vcnt < 16'(ind_mem[`VTP_IND_VSW])) ^ ind_mem[`VTP_IND_SYNC_CFG][1];
   assign gen_de = hcnt >= hstart &&
                   hcnt < hstart + ind16(ind_mem[`VTP_IND_HACT_LO], ind_mem[`VTP_IND_HACT_HI]) &&
                   vcnt >= vstart &&
                   vcnt < vstart + ind16(ind_mem[`VTP_IND_VACT_LO], ind_mem[`VTP_IND_VACT_HI]);

   // frame boundary: own counters wrap, or incoming vertical sync rises
   assign frame_end = tsel ? (tick && h_wrap && v_wrap) : (pin_q[24] && !vs_prev);

   // raster position; external mode counts pixels inside each enable run
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hcnt    <= `VTP_RST16;
         vcnt    <= `VTP_RST16;
         de_prev <= 1'b0;
      end else if (ce) begin
         if (!en) begin
            hcnt    <= `VTP_RST16;
            vcnt    <= `VTP_RST16;
            de_prev <= 1'b0;
         end else if (tsel) begin
            if (tick) begin
               hcnt <= h_wrap ? `VTP_RST16 : hcnt + `VTP_ONE16;
               if (h_wrap) begin
                  vcnt <= v_wrap ? `VTP_RST16 : vcnt + `VTP_ONE16;
               end
            end
         end else begin
            if (pin_q[24] && !vs_prev) begin
               vcnt <= `VTP_RST16;
            end else if (tick && de_prev && !pin_q[26]) begin
               vcnt <= vcnt + `VTP_ONE16;
            end
            if (tick) begin
               hcnt    <= pin_q[26] ? hcnt + `VTP_ONE16 : `VTP_RST16;
               de_prev <= pin_q[26];
            end
         end
      end
   end

   // auto-scroll; a frame time of zero advances every frame
   assign scroll_now = en && frame_end && pattern_config[`VTP_CFG_ASCRL] &&
                       frame_cnt + `VTP_ONE8 >= frame_time_setting;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_cnt <= `VTP_RST8;
         cur_pat   <= 3'd0;
      end else if (ce) begin
         if (!pattern_config[`VTP_CFG_ASCRL]) begin
            frame_cnt <= `VTP_RST8; // pattern held
         end else if (scroll_now) begin
            frame_cnt <= `VTP_RST8;
            cur_pat   <= next_pattern(cur_pat, ind_mem[`VTP_IND_PAT_MASK]);
         end else if (en && frame_end) begin
            frame_cnt <= frame_cnt + `VTP_ONE8;
         end
      end
   end

   // local colour at the current position, origin at the active window
   assign local_rgb = pattern_colour(cur_pat,
                                     tsel ? hcnt - hstart : hcnt,
                                     tsel ? vcnt - vstart : vcnt,
                                     depth18, pattern_config[`VTP_CFG_INV]);

   // video outputs, updated once per pixel
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vid_de  <= 1'b0;
         vid_hs  <= 1'b0;
         vid_vs  <= 1'b0;
         vid_rgb <= 24'h000000;
      end else if (ce) begin
         if (!en) begin
            vid_de  <= 1'b0;
            vid_hs  <= 1'b0;
            vid_vs  <= 1'b0;
            vid_rgb <= 24'h000000;
         end else if (tick) begin
            vid_de  <= tsel ? gen_de : pin_q[26];
            vid_hs  <= tsel ? gen_hs : pin_q[25];
            vid_vs  <= tsel ? gen_vs : pin_q[24];
            vid_rgb <= (tsel ? gen_de : pin_q[26]) ? local_rgb : 24'h000000;
         end
      end
   end

   // self-test compare; received colour masked to the same depth
   assign mismatch = en && pattern_debug_control[`VTP_DBG_BIST] && tick && pin_q[26] &&
                     ((pin_q[23:0] & (depth18 ? `VTP_MASK18 : `VTP_MASK24)) != local_rgb);

   // error count saturates; cleared when self-test is switched on
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bist_count <= `VTP_RST8;
         bist_prev  <= 1'b0;
      end else if (ce) begin
         bist_prev <= pattern_debug_control[`VTP_DBG_BIST];
         if (pattern_debug_control[`VTP_DBG_BIST] && !bist_prev) begin
            bist_count <= `VTP_RST8;
         end else if (mismatch && bist_count != `VTP_CNT_MAX) begin
            bist_count <= bist_count + `VTP_ONE8;
         end
      end
   end

   // sticky event bits, write one to clear; a new event wins over the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status <= `VTP_RST8;
      end else if (ce) begin
         irq_status <= (irq_status &
                        ~((wr_pend && acc_idx == `VTP_IDX_IRQ_STAT) ? hwdata[7:0] : `VTP_RST8)) |
                       {5'b00000, mismatch, scroll_now, en && frame_end};
      end
   end

   // level interrupt from a flop, one cycle behind the status
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(irq_status & irq_mask);
      end
   end

endmodule

// ---- sim/vtp_generator_asserts.sv ----
/*
 checker on the pattern generator ports.
 assumes a bind into vtp_generator, one hclk domain.
*/
module vtp_generator_asserts (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        ce,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   input wire logic        vid_de,
   input wire logic [23:0] vid_rgb,
   input wire logic        irq
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // transfer taken this edge
   wire logic take = hsel && hready && htrans[1] && ce;

   a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
   a_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("hrdata upper bits set");
   a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write waited");
   a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait not one cycle");
   a_wait_cause: assert property (!hreadyout |-> $past(take) && !$past(hwrite)) else $error("stray wait");
   a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("hrdata moved");
   a_ce_freeze: assert property (!ce |=> $stable(vid_rgb) && $stable(irq) && $stable(hreadyout))
      else $error("flops moved with ce low");
   // blanking stays black even when inverting, so invert applies to active pixels only
   a_blank_black: assert property (!vid_de |-> vid_rgb == 24'h0) else $error("colour in blanking");
endmodule

bind vtp_generator vtp_generator_asserts i_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
   .hresp(hresp), .vid_de(vid_de), .vid_rgb(vid_rgb), .irq(irq));

// ---- sim/vtp_upstream_model.sv ----
/*
 upstream video source: 16-pixel lines, 4-line frames, white pixels.
 assumes hclk at 25 MHz; pixel clock is hclk/8 and stands at 0 when idle.
*/
module vtp_upstream_model (
   input wire logic   hclk,
   input wire logic   run,
   input wire logic   bad,
   output logic       pclk,
   output logic       de,
   output logic       hs,
   output logic       vs,
   output logic [23:0] rgb
);
   logic [2:0] div = 3'h0;
   logic [3:0] pix = 4'h0;
   logic [1:0] line = 2'h0;
   // data moves on the falling pixel edge, so it is steady at the rise
   always_ff @(posedge hclk) begin
      div <= run ? div + 3'h1 : 3'h0;
      pclk <= run & div[2];
      if (run && div == 3'h7) begin
         pix <= pix + 4'h1;
         line <= (pix == 4'hf) ? line + 2'h1 : line;
      end
      de <= run && pix < 4'hc;
      hs <= run && pix == 4'he;
      vs <= run && line == 2'h0;
      rgb <= (bad && pix < 4'hc) ? 24'h00ff00 : 24'hffffff; // green only when told to differ
   end
endmodule

// ---- sim/tb.sv ----
/*
 testbench of the pattern generator: registers, indirect map, video modes, self-test.
 assumes the upstream model on the video pins and one ahb master here.
*/
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        ce = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic        run = 1'b0;
   logic        bad = 1'b0;
   logic        hreadyout, hresp, pclk, de, hs, vs, vid_de, vid_hs, vid_vs, irq;
   logic [31:0] hrdata, q;
   logic [23:0] rx, vid_rgb;
   int          n_errors = 0;
   int          n_tests = 0;
   // free-running 25 MHz clock
   always #20 hclk = ~hclk;

   vtp_upstream_model i_up (.hclk(hclk), .run(run), .bad(bad), .pclk(pclk), .de(de), .hs(hs),
      .vs(vs), .rgb(rx));
   vtp_generator i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_pclk(pclk), .ext_de(de),
      .ext_hs(hs), .ext_vs(vs), .rx_rgb(rx), .vid_de(vid_de), .vid_hs(vid_hs), .vid_vs(vid_vs),
      .vid_rgb(vid_rgb), .irq(irq));

   task automatic wrap_up;
      $display("errors %0d of %0d checks", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one bounded wait for hready sampled high
   task automatic rdy;
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_errors++;
         wrap_up;
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      hwrite <= w;
      htrans <= 2'b10;
      haddr <= {22'h0, idx, 2'b00};
      rdy;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      rdy;
      q = hrdata;
   endtask
   // waits for vid_de at the given level, bounded
   task automatic lvl(input logic v);
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (vid_de !== v && k < 900);
      if (k >= 900) begin
         n_errors++;
         wrap_up;
      end
   endtask

   task automatic t_regs;
      for (int i = 'h64; i <= 'h6c; i++) begin
         bus(0, i[7:0], 8'h00);
         chk("reset value", q, 32'h0);
      end
      bus(1, 8'h65, 8'hff);
      bus(0, 8'h65, 8'h00);
      chk("config", q, 32'h1f);
      bus(1, 8'h68, 8'hff);
      bus(0, 8'h68, 8'h00);
      chk("debug", q, 32'h08);
      // self-test off again, so later scenarios start from a zero count
      bus(1, 8'h68, 8'h00);
      bus(1, 8'h69, 8'hff);
      bus(0, 8'h69, 8'h00);
      chk("status ro", q, 32'h0);
      bus(1, 8'h70, 8'hff);
      bus(0, 8'h70, 8'h00);
      chk("unmapped", q, 32'h0);
   endtask
   task automatic t_ind;
      logic [7:0] a [3] = '{8'h09, 8'h0a, 8'h0d};
      foreach (a[i]) begin
         bus(1, 8'h66, a[i]);
         bus(1, 8'h67, a[i] ^ 8'ha5);
      end
      foreach (a[i]) begin
         bus(1, 8'h66, a[i]);
         bus(0, 8'h66, 8'h00);
         chk("ind addr", q, {24'h0, a[i]});
         bus(0, 8'h67, 8'h00);
         chk("ind data", q, {24'h0, a[i] ^ 8'ha5});
      end
   endtask
   // external timing: white in each colour setting, black when inverted; extclk set must not matter
   task automatic t_ext;
      logic [7:0] c [4] = '{8'h00, 8'h02, 8'h10, 8'h18};
      logic [23:0] e [4] = '{24'hffffff, 24'h000000, 24'hfcfcfc, 24'hfcfcfc};
      bus(1, 8'h64, 8'h01);
      run <= 1'b1;
      foreach (c[i]) begin
         bus(1, 8'h65, c[i]);
         lvl(0);
         lvl(1);
         chk("ext rgb", {8'h0, vid_rgb}, {8'h0, e[i]});
      end
      ce <= 1'b0;
      repeat (8) @(posedge hclk);
      ce <= 1'b1;
   endtask
   // self-timed frame with the pins idle, then the pixel clock source
   task automatic t_int;
      logic [7:0] a [8] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0c};
      logic [7:0] d [8] = '{8'h10, 8'h04, 8'h08, 8'h02, 8'h01, 8'h01, 8'h02, 8'h01};
      int n;
      int m;
      logic last;
      run <= 1'b0;
      foreach (a[i]) begin
         bus(1, 8'h66, a[i]);
         bus(1, 8'h67, d[i]);
      end
      bus(1, 8'h65, 8'h04);
      lvl(0);
      lvl(1);
      chk("int rgb", {8'h0, vid_rgb}, 32'hffffff);
      // one whole 128-cycle frame: hsync one pixel per line, vsync all of line 0
      n = 0;
      m = 0;
      repeat (128) begin
         @(posedge hclk);
         n += int'(vid_hs);
         m += int'(vid_vs);
      end
      chk("hs cycles", n, 8);
      chk("vs cycles", m, 32);
      bus(1, 8'h65, 8'h0c);
      repeat (6) @(posedge hclk);
      n = 0;
      last = vid_de;
      repeat (100) begin
         @(posedge hclk);
         n += (vid_de !== last);
         last = vid_de;
      end
      chk("frozen", n, 0);
      run <= 1'b1;
      lvl(1'b0);
      lvl(1'b1);
      chk("pclk rgb", {8'h0, vid_rgb}, 32'hffffff);
   endtask
   task automatic t_bist;
      int k;
      bus(1, 8'h65, 8'h00);
      bus(1, 8'h6c, 8'h04);
      bus(1, 8'h68, 8'h08);
      repeat (300) @(posedge hclk);
      bus(0, 8'h69, 8'h00);
      chk("no err", q, 32'h0);
      chk("irq masked", irq, 1'b0);
      bad <= 1'b1;
      k = 0;
      while (irq !== 1'b1 && k < 900) begin
         @(posedge hclk);
         k++;
      end
      chk("irq", irq, 1'b1);
      bus(0, 8'h69, 8'h00);
      chk("err flag", q, 32'h80);
      bus(0, 8'h6b, 8'h00);
      chk("mism bit", q & 32'h4, 32'h4);
      bad <= 1'b0;
      repeat (40) @(posedge hclk);
      bus(1, 8'h6b, 8'h07);
      bus(0, 8'h6b, 8'h00);
      chk("irq clear", irq, 1'b0);
   endtask
   // auto-scroll from white to the one enabled pattern, the red ramp, then held there
   task automatic t_scroll;
      bus(1, 8'h66, 8'h00);
      bus(1, 8'h67, 8'h02);
      bus(1, 8'h6a, 8'h00);
      bus(1, 8'h65, 8'h05);
      repeat (300) @(posedge hclk);
      bus(0, 8'h6b, 8'h00);
      chk("scroll bit", q & 32'h2, 32'h2);
      lvl(1'b0);
      lvl(1'b1);
      // second active pixel, one divided tick later, has ramp level one
      @(posedge hclk);
      @(posedge hclk);
      chk("ramp px1", {8'h0, vid_rgb}, 32'h010000);
   endtask

   // main sequence
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_ind;
      t_ext;
      t_int;
      t_bist;
      t_scroll;
      wrap_up;
   end
endmodule
